// [design/status_pkg.sv]
// Shared constants, register map and encodings of the drive status publisher.
package status_pkg;
   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_CONFIG     = 8'h00;
   localparam logic [7:0] OFS_PID_GAIN   = 8'h04;
   localparam logic [7:0] OFS_MAX_SEND   = 8'h08;
   localparam logic [7:0] OFS_MIN_SEND   = 8'h0C;
   localparam logic [7:0] OFS_MIN_DELTA  = 8'h10;
   localparam logic [7:0] OFS_IN_FUNC_LO = 8'h14;
   localparam logic [7:0] OFS_IN_FUNC_HI = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;
   localparam logic [7:0] OFS_PID_VALUE  = 8'h24;
   localparam logic [7:0] OFS_ALARM      = 8'h28;
   localparam logic [7:0] OFS_READ_STAT  = 8'h2C;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int         CFG_SRC_LSB   = 0;
   localparam int         CFG_LINK_LSB  = 8;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] GAIN_RESET   = 32'h0000_0100;
   localparam logic [31:0] ZERO_RESET   = 32'h0000_0000;
   localparam int         GAIN_SHIFT    = 8;
   localparam int         IRQ_PID       = 0;
   localparam int         IRQ_SWITCH    = 1;
   localparam int         IRQ_ALARM     = 2;
   localparam int         IRQ_READ      = 3;
   localparam int         IRQ_BITS      = 4;

   // ----------------------------------------------------------------------
   // Value encodings
   // ----------------------------------------------------------------------
   localparam logic [15:0] PID_MAX       = 16'h7FFE;
   localparam logic [7:0]  SWITCH_ON     = 8'hC8;
   localparam logic [7:0]  SWITCH_OFF    = 8'h00;
   localparam logic [7:0]  FUNC_GP_INPUT = 8'h19;
   localparam logic [1:0]  LINK_FUNC_ALL = 2'h0;
   localparam logic [1:0]  SRC_NONE      = 2'h0;
   localparam logic [7:0]  ALARM_NONE    = 8'h00;
   localparam int          FAULTS        = 8;
   // Fault inputs in priority order: overcurrent accel, decel, constant,
   // undervoltage, save failure, card connection, fieldbus, serial link.
   localparam logic [7:0]  FAULT_CODE [FAULTS] =
      '{8'h01, 8'h02, 8'h03, 8'h0A, 8'h33, 8'h22, 8'h23, 8'h26};

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLOCK_NS     = 10;
   localparam int SEND_TICK_NS = 1000000;
   localparam int TICK_CYCLES  = SEND_TICK_NS / CLOCK_NS;

   typedef enum {RD_IDLE, RD_ASK} read_state_e;
endpackage

// [design/send_cfg_if.sv]
// Send-interval configuration and time tick shared with each send scheduler.
`timescale 1ns/1ps
interface send_cfg_if;
   logic        tick;
   logic [15:0] max_interval;
   logic [15:0] min_interval;
   logic [15:0] min_change_delta;

   modport source
   (
      output tick,
      output max_interval,
      output min_interval,
      output min_change_delta
   );
   modport sched
   (
      input tick,
      input max_interval,
      input min_interval,
      input min_change_delta
   );
endinterface

// [design/send_scheduler.sv]
// Decides when one published value is sent: on change, periodically, paced.
`timescale 1ns/1ps
module send_scheduler
#(
   parameter int W         = 16,
   parameter bit PERIODIC  = 1'b1,
   parameter bit USE_DELTA = 1'b0
)
(
   input  wire logic   clock_in,
   input  wire logic   srst_in,
   send_cfg_if.sched   cfg,
   input  wire logic [W-1:0] value_in,
   input  wire logic   force_in,
   output logic        send_out
);
   logic [W-1:0] last_reg;
   logic [15:0]  since_reg;
   logic         send_reg;
   logic [W-1:0] diff;
   logic         changed;
   logic         delta_hit;
   logic         period_hit;
   logic         allowed;
   logic         want;

   assign diff       = (value_in > last_reg) ? value_in - last_reg : last_reg - value_in;
   assign delta_hit  = (cfg.min_change_delta == 16'h0000) ||
                       (diff > W'(cfg.min_change_delta));
   assign changed    = (value_in != last_reg) && (!USE_DELTA || delta_hit);
   assign period_hit = PERIODIC && (cfg.max_interval != 16'h0000) &&
                       (since_reg >= cfg.max_interval);
   assign allowed    = (cfg.min_interval == 16'h0000) ||
                       (since_reg >= cfg.min_interval);
   assign want       = (changed || period_hit || force_in) && allowed;
   assign send_out   = send_reg;

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         last_reg  <= '0;
         since_reg <= 16'h0000;
         send_reg  <= 1'b0;
      end
      else
      begin
         send_reg <= want || (force_in && !PERIODIC);
         if (want || force_in)
         begin
            last_reg  <= value_in;
            since_reg <= 16'h0000;
         end
         else if (cfg.tick && since_reg != 16'hFFFF)
         begin
            since_reg <= since_reg + 16'h0001;
         end
      end
   end
endmodule

// [design/drive_status_publisher.sv]
// Drive status publisher: register slave, status values, alarms and readout.
`timescale 1ns/1ps
// What this block does
// - Report selected analog input as PID percentage.
// - Gain setting scales published PID feedback.
// - Send levels on change, periodically, paced.
// - Publish output terminals as 0/100% switches.
// - Fourth output status exists but stays inactive.
// - Publish acceptance of five input terminals.
// - Link setting 0 adds network command acceptance.
// - Function 25 publishes raw terminal state.
// - One-byte alarm code, zero means none.
// - Power fault codes 1,2,3,10,51.
// - Link fault codes 34,35,38.
// - Alarms sent on change only, paced.
// - Three-byte history, most recent first.
// - Return read value and end readout on the same edge.
// - Ignore read requests during a readout.
// - Send read result after every accepted request.
module drive_status_publisher
#(
   parameter int TICK_CYCLES = status_pkg::TICK_CYCLES
)
(
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic             irq_out,
   input  wire logic [47:0] analog_level_in,
   input  wire logic [3:0]  dout_terminal_in,
   input  wire logic [4:0]  din_physical_in,
   input  wire logic [4:0]  din_term_accepted_in,
   input  wire logic [4:0]  din_net_accepted_in,
   input  wire logic [7:0]  fault_event_in,
   input  wire logic        other_alarm_valid_in,
   input  wire logic [7:0]  other_alarm_code_in,
   input  wire logic        net_read_req_valid_in,
   input  wire logic [15:0] net_read_req_id_in,
   input  wire logic        param_ack_in,
   input  wire logic [15:0] param_data_in,
   output logic      [15:0] pid_feedback_out,
   output logic             pid_send_out,
   output logic      [4:0]  out_switch_state_out,
   output logic      [39:0] out_switch_value_out,
   output logic             out_switch_send_out,
   output logic      [4:0]  in_switch_state_out,
   output logic      [39:0] in_switch_value_out,
   output logic             in_switch_send_out,
   output logic      [7:0]  alarm_code_out,
   output logic      [23:0] alarm_history_out,
   output logic             alarm_send_out,
   output logic             param_req_out,
   output logic      [15:0] param_id_out,
   output logic      [15:0] param_read_result_out,
   output logic             param_read_result_send_out
);
   import status_pkg::*;

   // ----------------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------------
   logic [31:0] config_reg;
   logic [31:0] gain_reg;
   logic [31:0] max_send_reg;
   logic [31:0] min_send_reg;
   logic [31:0] delta_reg;
   logic [31:0] in_func_lo_reg;
   logic [31:0] in_func_hi_reg;
   logic [31:0] mask_reg;
   logic [IRQ_BITS-1:0] status_reg;
   logic [IRQ_BITS-1:0] status_next;
   logic [31:0] readdata_reg;
   logic        wait_reg;
   logic        irq_reg;

   wire         bus_req    = avs_read_in || avs_write_in;
   wire         bus_done   = bus_req && !wait_reg;
   wire         wr_done    = bus_done && avs_write_in;
   wire         rd_done    = bus_done && avs_read_in;
   wire  [31:0] be_mask    = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                              {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   wire         wr_config  = wr_done && avs_address_in == OFS_CONFIG;
   wire         wr_gain    = wr_done && avs_address_in == OFS_PID_GAIN;
   wire         wr_max     = wr_done && avs_address_in == OFS_MAX_SEND;
   wire         wr_min     = wr_done && avs_address_in == OFS_MIN_SEND;
   wire         wr_delta   = wr_done && avs_address_in == OFS_MIN_DELTA;
   wire         wr_func_lo = wr_done && avs_address_in == OFS_IN_FUNC_LO;
   wire         wr_func_hi = wr_done && avs_address_in == OFS_IN_FUNC_HI;
   wire         wr_mask    = wr_done && avs_address_in == OFS_IRQ_MASK;
   wire         rd_status  = rd_done && avs_address_in == OFS_IRQ_STATUS;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         config_reg     <= CONFIG_RESET;
         gain_reg       <= GAIN_RESET;
         max_send_reg   <= ZERO_RESET;
         min_send_reg   <= ZERO_RESET;
         delta_reg      <= ZERO_RESET;
         in_func_lo_reg <= ZERO_RESET;
         in_func_hi_reg <= ZERO_RESET;
         mask_reg       <= ZERO_RESET;
      end
      else
      begin
         if (wr_config)  config_reg     <= merge(config_reg, avs_writedata_in, be_mask);
         if (wr_gain)    gain_reg       <= merge(gain_reg, avs_writedata_in, be_mask);
         if (wr_max)     max_send_reg   <= merge(max_send_reg, avs_writedata_in, be_mask);
         if (wr_min)     min_send_reg   <= merge(min_send_reg, avs_writedata_in, be_mask);
         if (wr_delta)   delta_reg      <= merge(delta_reg, avs_writedata_in, be_mask);
         if (wr_func_lo) in_func_lo_reg <= merge(in_func_lo_reg, avs_writedata_in, be_mask);
         if (wr_func_hi) in_func_hi_reg <= merge(in_func_hi_reg, avs_writedata_in, be_mask);
         if (wr_mask)    mask_reg       <= merge(mask_reg, avs_writedata_in, be_mask);
      end
   end

   // ----------------------------------------------------------------------
   // Read mux and waitrequest
   // ----------------------------------------------------------------------
   logic [31:0] rd_mux;
   logic [15:0] pid_reg;
   logic [7:0]  alarm_reg;
   logic [23:0] history_reg;
   logic        rd_busy;
   logic [15:0] req_id_reg;

   always_comb
   begin
      unique case (avs_address_in)
         OFS_CONFIG:     rd_mux = config_reg;
         OFS_PID_GAIN:   rd_mux = gain_reg;
         OFS_MAX_SEND:   rd_mux = max_send_reg;
         OFS_MIN_SEND:   rd_mux = min_send_reg;
         OFS_MIN_DELTA:  rd_mux = delta_reg;
         OFS_IN_FUNC_LO: rd_mux = in_func_lo_reg;
         OFS_IN_FUNC_HI: rd_mux = in_func_hi_reg;
         OFS_IRQ_STATUS: rd_mux = {{(32-IRQ_BITS){1'b0}}, status_reg};
         OFS_IRQ_MASK:   rd_mux = mask_reg;
         OFS_PID_VALUE:  rd_mux = {16'h0000, pid_reg};
         OFS_ALARM:      rd_mux = {history_reg, alarm_reg};
         OFS_READ_STAT:  rd_mux = {15'h0000, rd_busy, req_id_reg};
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         wait_reg     <= 1'b1;
         readdata_reg <= 32'h0000_0000;
      end
      else
      begin
         wait_reg <= !(bus_req && wait_reg);
         if (bus_req && wait_reg)
         begin
            readdata_reg <= avs_read_in ? rd_mux : 32'h0000_0000;
         end
      end
   end

   assign avs_readdata_out    = readdata_reg;
   assign avs_waitrequest_out = wait_reg;

   // ----------------------------------------------------------------------
   // Send timing: millisecond tick and schedulers
   // ----------------------------------------------------------------------
   localparam int TICK_W = $clog2(TICK_CYCLES);
   logic [TICK_W-1:0] tick_cnt_reg;
   logic              tick_reg;
   send_cfg_if        cfg ();

   always_ff @(posedge clock_in)
   begin
      if (srst_in || tick_cnt_reg == TICK_W'(TICK_CYCLES - 1))
         tick_cnt_reg <= '0;
      else
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg <= !srst_in && tick_cnt_reg == TICK_W'(TICK_CYCLES - 1);
   end

   assign cfg.tick             = tick_reg;
   assign cfg.max_interval     = max_send_reg[15:0];
   assign cfg.min_interval     = min_send_reg[15:0];
   assign cfg.min_change_delta = delta_reg[15:0];

   // ----------------------------------------------------------------------
   // PID feedback level
   // ----------------------------------------------------------------------
   wire  [1:0]  pid_src   = config_reg[CFG_SRC_LSB +: 2];
   wire  [15:0] pid_raw   = (pid_src == SRC_NONE) ? 16'h0000 :
                            analog_level_in[16*(pid_src-2'h1) +: 16];
   wire  [31:0] pid_prod  = pid_raw * gain_reg[15:0];
   wire  [23:0] pid_scale = pid_prod[GAIN_SHIFT +: 24];
   wire  [15:0] pid_next  = (pid_scale > {8'h00, PID_MAX}) ? PID_MAX : pid_scale[15:0];

   // ----------------------------------------------------------------------
   // Digital output and input switch states
   // ----------------------------------------------------------------------
   logic [4:0]  out_state_reg;
   logic [4:0]  in_state_reg;
   wire  [4:0]  out_next = {dout_terminal_in[3], 1'b0, dout_terminal_in[2:0]};
   wire  [39:0] in_funcs = {in_func_hi_reg[7:0], in_func_lo_reg};
   wire  [1:0]  link_func = config_reg[CFG_LINK_LSB +: 2];
   logic [4:0]  in_next;

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_switch
         assign in_next[gi] = (in_funcs[8*gi +: 8] == FUNC_GP_INPUT) ? din_physical_in[gi] :
                              din_term_accepted_in[gi] ||
                              (link_func == LINK_FUNC_ALL && din_net_accepted_in[gi]);
         assign out_switch_value_out[8*gi +: 8] = out_state_reg[gi] ? SWITCH_ON : SWITCH_OFF;
         assign in_switch_value_out[8*gi +: 8]  = in_state_reg[gi] ? SWITCH_ON : SWITCH_OFF;
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Alarm code and history
   // ----------------------------------------------------------------------
   logic [7:0] fault_code;
   logic       fault_any;

   always_comb
   begin
      fault_code = other_alarm_code_in;
      fault_any  = other_alarm_valid_in;
      for (int i = FAULTS - 1; i >= 0; i--)
      begin
         if (fault_event_in[i])
         begin
            fault_code = FAULT_CODE[i];
            fault_any  = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         pid_reg       <= 16'h0000;
         out_state_reg <= 5'h00;
         in_state_reg  <= 5'h00;
         alarm_reg     <= ALARM_NONE;
         history_reg   <= 24'h000000;
      end
      else
      begin
         pid_reg       <= pid_next;
         out_state_reg <= out_next;
         in_state_reg  <= in_next;
         if (fault_any)
         begin
            alarm_reg   <= fault_code;
            history_reg <= {fault_code, history_reg[23:8]};
         end
      end
   end

   assign pid_feedback_out     = pid_reg;
   assign out_switch_state_out = out_state_reg;
   assign in_switch_state_out  = in_state_reg;
   assign alarm_code_out       = alarm_reg;
   assign alarm_history_out    = history_reg;

   send_scheduler #(.W(16), .PERIODIC(1'b1), .USE_DELTA(1'b1)) u_pid_send
   (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .cfg      (cfg),
      .value_in (pid_reg),
      .force_in (1'b0),
      .send_out (pid_send_out)
   );
   send_scheduler #(.W(5), .PERIODIC(1'b1), .USE_DELTA(1'b0)) u_out_send
   (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .cfg      (cfg),
      .value_in (out_state_reg),
      .force_in (1'b0),
      .send_out (out_switch_send_out)
   );
   send_scheduler #(.W(5), .PERIODIC(1'b1), .USE_DELTA(1'b0)) u_in_send
   (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .cfg      (cfg),
      .value_in (in_state_reg),
      .force_in (1'b0),
      .send_out (in_switch_send_out)
   );
   send_scheduler #(.W(32), .PERIODIC(1'b0), .USE_DELTA(1'b0)) u_alarm_send
   (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .cfg      (cfg),
      .value_in ({alarm_reg, history_reg}),
      .force_in (1'b0),
      .send_out (alarm_send_out)
   );

   // ----------------------------------------------------------------------
   // Parameter readout
   // ----------------------------------------------------------------------
   read_state_e rd_state_reg;
   logic        param_req_reg;
   logic [15:0] result_reg;
   logic        result_send_reg;
   wire         req_take = rd_state_reg == RD_IDLE && net_read_req_valid_in;
   wire         req_end  = rd_state_reg == RD_ASK && param_ack_in;

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         rd_state_reg    <= RD_IDLE;
         param_req_reg   <= 1'b0;
         req_id_reg      <= 16'h0000;
         result_reg      <= 16'h0000;
         result_send_reg <= 1'b0;
      end
      else
      begin
         result_send_reg <= req_end;
         unique case (rd_state_reg)
            RD_IDLE:
            begin
               if (req_take)
               begin
                  req_id_reg    <= net_read_req_id_in;
                  param_req_reg <= 1'b1;
                  rd_state_reg  <= RD_ASK;
               end
            end
            RD_ASK:
            begin
               if (req_end)
               begin
                  result_reg    <= param_data_in;
                  param_req_reg <= 1'b0;
                  rd_state_reg  <= RD_IDLE;
               end
            end
         endcase
      end
   end

   assign rd_busy                    = rd_state_reg == RD_ASK;
   assign param_req_out              = param_req_reg;
   assign param_id_out               = req_id_reg;
   assign param_read_result_out      = result_reg;
   assign param_read_result_send_out = result_send_reg;

   // ----------------------------------------------------------------------
   // Interrupt status, read-to-clear; a new event wins over the clear.
   // ----------------------------------------------------------------------
   wire [IRQ_BITS-1:0] events = {result_send_reg, alarm_send_out,
                                 out_switch_send_out || in_switch_send_out, pid_send_out};

   assign status_next = (status_reg & ~(rd_status ? readdata_reg[IRQ_BITS-1:0] : {IRQ_BITS{1'b0}}))
                        | events;

   always_ff @(posedge clock_in)
   begin
      if (srst_in)
      begin
         status_reg <= {IRQ_BITS{1'b0}};
         irq_reg    <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         irq_reg    <= |(status_next & mask_reg[IRQ_BITS-1:0]);
      end
   end

   assign irq_out = irq_reg;
endmodule

// [tb/param_store_model.sv]
// Model of the drive's parameter store that answers readout requests.
`timescale 1ns/1ps
module param_store_model
#(
   parameter int DELAY = 5
)
(
   input  wire logic        clock_in,
   input  wire logic        srst_in,
   input  wire logic        req_in,
   input  wire logic [15:0] id_in,
   output logic             ack_out = 1'b0,
   output logic      [15:0] data_out = 16'h0000
);
   int wait_reg;

   // Data lines toggle every cycle unless an answer is being given.
   always_ff @(posedge clock_in)
   begin
      ack_out <= 1'b0;
      data_out <= ~data_out;
      if (srst_in || !req_in)
         wait_reg <= 0;
      else if (wait_reg == DELAY)
      begin
         ack_out <= 1'b1;
         data_out <= id_in ^ 16'hA5A5;
         wait_reg <= DELAY + 1;
      end
      else if (wait_reg < DELAY)
         wait_reg <= wait_reg + 1;
   end
endmodule

// [tb/publisher_properties.sv]
// Concurrent checks on the drive status publisher ports.
`timescale 1ns/1ps
module publisher_properties
(
   input wire logic        clock_in, srst_in, avs_waitrequest_out, net_read_req_valid_in,
   input wire logic        param_req_out, param_ack_in, param_read_result_send_out,
   input wire logic [15:0] net_read_req_id_in, param_id_out, param_data_in,
   input wire logic [15:0] param_read_result_out, pid_feedback_out,
   input wire logic [4:0]  out_switch_state_out,
   input wire logic [39:0] out_switch_value_out,
   input wire logic [7:0]  fault_event_in, alarm_code_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (srst_in);
   sequence accept_s; !param_req_out && net_read_req_valid_in; endsequence
   sequence answer_s; param_req_out && param_ack_in; endsequence

   wait_one_a: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   read_start_a: assert property (accept_s |=>
      param_req_out && param_id_out == $past(net_read_req_id_in))
      else $error("readout not started");
   id_hold_a: assert property (param_req_out && !param_ack_in |=>
      param_req_out && $stable(param_id_out)) else $error("identifier moved");
   read_end_a: assert property (answer_s |=> !param_req_out &&
      param_read_result_send_out && param_read_result_out == $past(param_data_in))
      else $error("readout result wrong");
   send_pulse_a: assert property (param_read_result_send_out |=>
      !param_read_result_send_out) else $error("result send too long");
   unused_out_a: assert property (out_switch_state_out[3] == 1'b0)
      else $error("fourth output status active");
   relay_value_a: assert property (out_switch_value_out[39:32] ==
      (out_switch_state_out[4] ? 8'hC8 : 8'h00)) else $error("relay value wrong");
   pid_range_a: assert property (pid_feedback_out <= 16'h7FFE)
      else $error("feedback over range");
   fault_code_a: assert property (fault_event_in[0] |-> ##[1:2]
      alarm_code_out == 8'h01) else $error("overcurrent code wrong");
   link_code_a: assert property (fault_event_in == 8'h40 |-> ##[1:2]
      alarm_code_out == 8'h23) else $error("fieldbus code wrong");
endmodule
bind drive_status_publisher publisher_properties checker_i (.*);

// [tb/testbench.sv]
// Self-checking bench of the drive status publisher.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   import status_pkg::*;
   logic clock_in = 0, srst_in = 1, avs_read_in = 0, avs_write_in = 0, net_read_req_valid_in = 0;
   logic param_ack_in, param_req_out, avs_waitrequest_out, irq_out, pid_send_out;
   logic alarm_send_out, param_read_result_send_out, out_switch_send_out, in_switch_send_out;
   logic [7:0] avs_address_in = 0, fault_event_in = 0, alarm_code_out;
   logic [31:0] avs_writedata_in = 0, avs_readdata_out, rdata;
   logic [47:0] analog_level_in = 0;
   logic [3:0] dout_terminal_in = 0;
   logic [4:0] din_physical_in = 0, din_term_accepted_in = 0, din_net_accepted_in = 0;
   logic [4:0] out_switch_state_out, in_switch_state_out;
   logic [15:0] net_read_req_id_in = 0, param_data_in, param_id_out, pid_feedback_out;
   logic [15:0] param_read_result_out;
   logic [39:0] out_switch_value_out, in_switch_value_out;
   logic [23:0] alarm_history_out;
   int n_errors = 0, samples_checked = 0, n_pid = 0, n_alarm = 0, n_read = 0, n_sw = 0, p;
   logic [15:0] rows [8] = '{16'h0101, 16'h0202, 16'h0403, 16'h080A,
                             16'h1033, 16'h2022, 16'h4023, 16'h8026};

   drive_status_publisher #(.TICK_CYCLES(4)) uut (.*, .avs_byteenable_in(4'hF),
      .other_alarm_valid_in(1'b0), .other_alarm_code_in(8'h00));
   param_store_model model (.clock_in(clock_in), .srst_in(srst_in), .req_in(param_req_out),
      .id_in(param_id_out), .ack_out(param_ack_in), .data_out(param_data_in));

   always #5 clock_in = ~clock_in;
   always @(posedge clock_in)
   begin
      n_pid <= n_pid + pid_send_out;
      n_alarm <= n_alarm + alarm_send_out;
      n_read <= n_read + param_read_result_send_out;
      n_sw <= n_sw + out_switch_send_out + in_switch_send_out;
   end

   task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
      rdata = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask

   task automatic settle(int n);
      repeat (n) @(posedge clock_in);
      @(negedge clock_in);
   endtask

   task automatic summarize();
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clock_in);
      n_errors++;
      summarize();
   end

   initial
   begin
      repeat (6) @(posedge clock_in);
      srst_in <= 1'b0;
      settle(1);
      `CHK(alarm_code_out, ALARM_NONE)
      bus(0, OFS_PID_GAIN, 0);
      `CHK(rdata, 32'h0000_0100)
      bus(0, 8'hFC, 0);
      `CHK(rdata, 32'h0000_0000)
      foreach (rows[i])
      begin
         @(posedge clock_in);
         fault_event_in <= rows[i][15:8];
         @(posedge clock_in);
         fault_event_in <= 8'h00;
         settle(3);
         `CHK(alarm_code_out, rows[i][7:0])
      end
      `CHK(alarm_history_out, 24'h262322)
      `CHK(n_alarm, 8)
      bus(1, OFS_IRQ_MASK, 32'h8);
      bus(1, OFS_CONFIG, 32'h2);
      bus(1, OFS_PID_GAIN, 32'h200);
      analog_level_in <= 48'h0000_1000_0000;
      settle(4);
      `CHK(pid_feedback_out, 16'h2000)
      @(posedge clock_in);
      analog_level_in <= 48'h0000_5000_0000;
      settle(4);
      `CHK(pid_feedback_out, PID_MAX)
      bus(1, OFS_MAX_SEND, 32'h2);
      p = n_pid;
      settle(40);
      `CHK(n_pid > p + 2, 1'b1)
      `CHK(n_sw > 4, 1'b1)
      `CHK(n_alarm, 8)
      @(posedge clock_in);
      dout_terminal_in <= 4'b1001;
      din_term_accepted_in <= 5'b00011;
      din_net_accepted_in <= 5'b00100;
      settle(4);
      `CHK(out_switch_state_out, 5'b10001)
      `CHK(out_switch_value_out, 40'hC8000000C8)
      `CHK(in_switch_state_out, 5'b00111)
      `CHK(in_switch_value_out, 40'h0000C8C8C8)
      bus(1, OFS_IN_FUNC_LO, 32'h19);
      settle(3);
      `CHK(in_switch_state_out, 5'b00110)
      bus(1, OFS_CONFIG, 32'h102);
      settle(3);
      `CHK(in_switch_state_out, 5'b00010)
      repeat (2)
      begin
         @(posedge clock_in);
         net_read_req_valid_in <= 1'b1;
         net_read_req_id_in <= 16'h0417;
         @(posedge clock_in);
         net_read_req_id_in <= 16'h0A0A;
         @(posedge clock_in);
         net_read_req_valid_in <= 1'b0;
         settle(10);
         `CHK(param_read_result_out, 16'h0417 ^ 16'hA5A5)
      end
      `CHK(n_read, 2)
      `CHK(irq_out, 1'b1)
      bus(0, OFS_IRQ_STATUS, 0);
      `CHK(rdata[IRQ_BITS-1:0], 4'hF)
      settle(2);
      `CHK(irq_out, 1'b0)
      @(posedge clock_in);
      srst_in <= 1'b1;
      @(posedge clock_in);
      srst_in <= 1'b0;
      settle(1);
      `CHK({alarm_code_out, alarm_history_out, pid_feedback_out}, 48'h0)
      `CHK(avs_waitrequest_out, 1'b1)
      summarize();
   end
endmodule
